// ### hw/rssi_cal_pkg.sv
// Constants, register map and encodings for the signal-level, gain and image-trim block.
// Assumes a 100 MHz bus clock shared by every file of the block.
package rssi_cal_pkg;

  localparam int CLK_PERIOD_NS = 10;
  // Time given to the level filter to follow each new trim combination.
  localparam int TRIM_SETTLE_NS = 20000;
  localparam int TRIM_SETTLE_CYCLES = (TRIM_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int IQ_TRIM_W = 7;
  localparam int LEVEL_RAW_W = 6;
  localparam int LEVEL_W = 8;
  localparam int FILT_SEL_W = 4;
  localparam int FILT_BASE_SHIFT = 5;
  localparam int HIGH_GAIN_W = 5;
  localparam int LOW_GAIN_W = 4;
  localparam int GAIN_STEP_W = 7;

  localparam logic [7:0] ADDR_TRIM = 8'h00;
  localparam logic [7:0] ADDR_BW = 8'h04;
  localparam logic [7:0] ADDR_GAIN = 8'h08;
  localparam logic [7:0] ADDR_THR = 8'h0C;
  localparam logic [7:0] ADDR_STEP = 8'h10;
  localparam logic [7:0] ADDR_LEVEL = 8'h14;
  localparam logic [7:0] ADDR_CMD = 8'h18;

  localparam int TRIM_START_BIT = 7;
  localparam int TRIM_ACTIVE_BIT = 8;
  localparam int GAIN_LOW_LSB = 8;
  localparam int LEVEL_LOWGAIN_BIT = 8;
  localparam int CMD_SUB_LSB = 0;
  localparam int CMD_GSEL_LSB = 2;
  localparam int CMD_WAKEUP_BIT = 4;
  localparam int CMD_SWEN_BIT = 5;

  localparam logic [IQ_TRIM_W-1:0] TRIM_RST = 7'h00;
  localparam logic [FILT_SEL_W-1:0] FILT_SEL_RST = 4'h0;
  localparam logic [HIGH_GAIN_W-1:0] HIGH_GAIN_RST = 5'h0F;
  localparam logic [LOW_GAIN_W-1:0] LOW_GAIN_RST = 4'h0;
  localparam logic [LEVEL_W-1:0] THR_RST = 8'h20;
  localparam logic [GAIN_STEP_W-1:0] GAIN_STEP_RST = 7'h00;

  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    SUB_CONT = 2'h0,
    SUB_WAKEUP = 2'h1,
    SUB_PREAMBLE = 2'h2,
    SUB_DATA = 2'h3
  } sub_cmd_t;

  typedef enum logic [1:0] {
    GSEL_KEEP = 2'h0,
    GSEL_SWITCH = 2'h1,
    GSEL_LOW = 2'h2,
    GSEL_HIGH = 2'h3
  } gain_sel_t;

  typedef enum logic [1:0] {
    SW_IDLE = 2'h0,
    SW_SETTLE = 2'h1,
    SW_MEASURE = 2'h3
  } sweep_state_t;

endpackage

// ### hw/level_filter.sv
// First-order digital low-pass on the raw signal-level code.
// Assumes the raw code is already synchronous to hclk.
`timescale 1ns/1ps
module level_filter
  import rssi_cal_pkg::*;
#(
  parameter int RAW_W = LEVEL_RAW_W,
  parameter int SEL_W = FILT_SEL_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [RAW_W-1:0] raw,
  input wire logic [SEL_W-1:0] sel,
  output logic [RAW_W-1:0] level
);

  localparam int FRAC = FILT_BASE_SHIFT + (1 << SEL_W) - 1;
  localparam int ACC_W = RAW_W + FRAC;

  generate
    if (RAW_W < 1 || SEL_W < 1 || SEL_W > 4) begin : g_chk
      $error("level_filter: unsupported width");
    end
  endgenerate

  logic [ACC_W-1:0] acc_q;
  wire logic [5:0] shift = 6'(FILT_BASE_SHIFT) + 6'(sel);
  wire logic signed [ACC_W:0] diff = $signed({1'b0, raw, {FRAC{1'b0}}}) - $signed({1'b0, acc_q});
  wire logic signed [ACC_W:0] step = diff >>> shift;

  // Gain 2^-(5+sel) per clock puts the corner at fref / (2 pi 2^(5+sel)).
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_q + step[ACC_W-1:0];
    end
  end

  assign level = acc_q[ACC_W-1:FRAC];

endmodule

// ### hw/iq_trim_sweep.sv
// Sweep engine that tries every I/Q trim code and keeps the one with the lowest level.
// Assumes the level input follows the applied trim within the settle time.
`timescale 1ns/1ps
module iq_trim_sweep
  import rssi_cal_pkg::*;
#(
  parameter int TRIM_W = IQ_TRIM_W,
  parameter int LVL_W = LEVEL_RAW_W,
  parameter int SETTLE_CYCLES = TRIM_SETTLE_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic [LVL_W-1:0] level,
  output logic busy,
  output logic [TRIM_W-1:0] cur_q,
  output logic done,
  output logic [TRIM_W-1:0] best
);

  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);

  generate
    if (SETTLE_CYCLES < 1 || TRIM_W < 1) begin : g_chk
      $error("iq_trim_sweep: settle time or width too small");
    end
  endgenerate

  sweep_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [LVL_W-1:0] min_q;
  logic [TRIM_W-1:0] best_q;

  wire logic settle_done = cnt_q == CNT_W'(SETTLE_CYCLES - 1);
  wire logic last = &cur_q;
  wire logic lower = (cur_q == '0) || (level < min_q);
  wire logic measuring = state_q == SW_MEASURE;

  assign busy = state_q != SW_IDLE;
  assign done = measuring && last;
  assign best = lower ? cur_q : best_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= SW_IDLE;
      cnt_q <= '0;
      cur_q <= '0;
      min_q <= '0;
      best_q <= '0;
    end else begin
      unique case (state_q)
        SW_IDLE: begin
          if (start) begin
            state_q <= SW_SETTLE;
            cur_q <= '0;
            cnt_q <= '0;
          end
        end
        SW_SETTLE: begin
          cnt_q <= cnt_q + 1'b1;
          if (settle_done) begin
            state_q <= SW_MEASURE;
          end
        end
        SW_MEASURE: begin
          if (lower) begin
            min_q <= level;
            best_q <= cur_q;
          end
          if (last) begin
            state_q <= SW_IDLE;
          end else begin
            cur_q <= cur_q + 1'b1;
            cnt_q <= '0;
            state_q <= SW_SETTLE;
          end
        end
        default: state_q <= SW_IDLE;
      endcase
    end
  end

  property p_step;
    @(posedge hclk) disable iff (!hresetn)
    measuring && !last |=> cur_q == TRIM_W'($past(cur_q) + 1'b1) && state_q == SW_SETTLE;
  endproperty
  a_step: assert property (p_step) else $error("trim code did not advance by one");

  property p_full_settle;
    @(posedge hclk) disable iff (!hresetn)
    $rose(measuring) |-> $past(state_q == SW_SETTLE) && $past(settle_done);
  endproperty
  a_full_settle: assert property (p_full_settle) else $error("measured before settle ended");

endmodule

// ### hw/rssi_gain_iq_calibration.sv
// Top of the signal-level path: AHB-Lite registers, level filter, gain switching and image-trim search.
// Assumes raw level and limiter bits come from pins; the wakeup decision comes from logic on hclk.
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps

// How it works
// - Start bit launches the trim search
// - Active flag readable while the search runs
// - Every trim code tried, one measurement each
// - Lowest-level code stored in trim field
// - Filter gain code selects four gain steps
// - LNA gain code selects four gain steps
// - Level digitized as six-bit code
// - Four-bit field selects filter cutoff
// - Cutoff is fref over 2pi 2^(5+sel)
// - High-gain setting applied from reset
// - Over threshold in wakeup: go low gain
// - Wakeup readings need no software request
// - Latest level readable in status register
// - Low gain adds step offset to level
// - One-bit limiter I/Q drive demodulation
// - Wakeup command starts the wakeup search
// - Gain code 01 switches only with wakeup
module rssi_gain_iq_calibration
  import rssi_cal_pkg::*;
#(
  parameter int SETTLE_CYCLES = TRIM_SETTLE_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [LEVEL_RAW_W-1:0] level_raw,
  input wire logic lim_i,
  input wire logic lim_q,
  input wire logic wakeup_decision,
  output logic [IQ_TRIM_W-1:0] iq_trim,
  output logic [1:0] lna_gain,
  output logic [1:0] cf_gain,
  output logic gain_aux,
  output logic demod_bit
);

  logic [LEVEL_RAW_W-1:0] raw_m_q, raw_s_q;
  logic [1:0] lim_m_q, lim_s_q;
  logic lim_i_d_q;
  logic [IQ_TRIM_W-1:0] image_trim_q;
  logic [FILT_SEL_W-1:0] filt_sel_q;
  logic [HIGH_GAIN_W-1:0] high_gain_q;
  logic [LOW_GAIN_W-1:0] low_gain_q;
  logic [LEVEL_W-1:0] thr_q;
  logic [GAIN_STEP_W-1:0] step_q;
  logic [LEVEL_W-1:0] level_q;
  logic gain_low_q, wakeup_q, sw_en_q;
  logic dp_wr_q;
  logic [7:0] dp_addr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic [IQ_TRIM_W-1:0] iq_trim_q;
  logic [1:0] lna_gain_q, cf_gain_q;
  logic gain_aux_q, demod_q;

  wire logic [LEVEL_RAW_W-1:0] filt_level;
  wire logic trim_active;
  wire logic [IQ_TRIM_W-1:0] sweep_cur;
  wire logic sweep_done;
  wire logic [IQ_TRIM_W-1:0] sweep_best;

  // Multi-bit raw code passes a plain two-stage synchroniser; the converter must hold
  // its code stable for several clocks, which the slow analog path guarantees.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      raw_m_q <= '0;
      raw_s_q <= '0;
      lim_m_q <= '0;
      lim_s_q <= '0;
      lim_i_d_q <= 1'b0;
    end else begin
      raw_m_q <= level_raw;
      raw_s_q <= raw_m_q;
      lim_m_q <= {lim_q, lim_i};
      lim_s_q <= lim_m_q;
      lim_i_d_q <= lim_s_q[0];
    end
  end

  level_filter #(
    .RAW_W(LEVEL_RAW_W),
    .SEL_W(FILT_SEL_W)
  ) u_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .raw(raw_s_q),
    .sel(filt_sel_q),
    .level(filt_level)
  );

  // Bus address phase and data-phase decode.
  wire logic addr_take = hsel && hready && htrans[1];
  wire logic [7:0] a = haddr[7:0];
  wire logic wr_ok = addr_take && hwrite && (hsize == HSIZE_WORD);
  wire logic wr_trim = dp_wr_q && (dp_addr_q == ADDR_TRIM);
  wire logic wr_bw = dp_wr_q && (dp_addr_q == ADDR_BW);
  wire logic wr_gain = dp_wr_q && (dp_addr_q == ADDR_GAIN);
  wire logic wr_thr = dp_wr_q && (dp_addr_q == ADDR_THR);
  wire logic wr_step = dp_wr_q && (dp_addr_q == ADDR_STEP);
  wire logic cmd_wr = dp_wr_q && (dp_addr_q == ADDR_CMD);

  wire logic [31:0] rd_word =
    (a == ADDR_TRIM) ? {23'h0, trim_active, 1'b0, image_trim_q} :
    (a == ADDR_BW) ? {28'h0, filt_sel_q} :
    (a == ADDR_GAIN) ? {20'h0, low_gain_q, 3'h0, high_gain_q} :
    (a == ADDR_THR) ? {24'h0, thr_q} :
    (a == ADDR_STEP) ? {25'h0, step_q} :
    (a == ADDR_LEVEL) ? {23'h0, gain_low_q, level_q} :
    (a == ADDR_CMD) ? {26'h0, sw_en_q, wakeup_q, 4'h0} : 32'h0;

  // Trim search: a start while busy is dropped, and a trim write during the sweep is
  // ignored so the stored result cannot be corrupted mid-search.
  wire logic trim_start = wr_trim && hwdata[TRIM_START_BIT] && !trim_active;
  wire logic [IQ_TRIM_W-1:0] image_trim_d = sweep_done ? sweep_best :
    (wr_trim && !trim_active) ? hwdata[IQ_TRIM_W-1:0] : image_trim_q;
  wire logic [IQ_TRIM_W-1:0] iq_trim_d = trim_active && !sweep_done ? sweep_cur : image_trim_d;

  iq_trim_sweep #(
    .TRIM_W(IQ_TRIM_W),
    .LVL_W(LEVEL_RAW_W),
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_sweep (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(trim_start),
    .level(filt_level),
    .busy(trim_active),
    .cur_q(sweep_cur),
    .done(sweep_done),
    .best(sweep_best)
  );

  // Receive command: sub-command and gain selection.
  wire sub_cmd_t cmd_sub = sub_cmd_t'(hwdata[CMD_SUB_LSB +: 2]);
  wire gain_sel_t cmd_gsel = gain_sel_t'(hwdata[CMD_GSEL_LSB +: 2]);
  wire logic cmd_wakeup = cmd_wr && (cmd_sub == SUB_WAKEUP);
  wire logic cmd_restart = cmd_wr && (cmd_sub != SUB_CONT);
  wire logic wakeup_d = cmd_wakeup ? 1'b1 : (cmd_restart || wakeup_decision) ? 1'b0 : wakeup_q;
  // Switching is armed only for the life of a wakeup search, so its end disarms it too.
  wire logic sw_en_d = cmd_wakeup ? (cmd_gsel == GSEL_SWITCH) :
    (cmd_restart || wakeup_decision) ? 1'b0 : sw_en_q;

  wire logic [LEVEL_W-1:0] comp_add = gain_low_q ? LEVEL_W'(step_q) : '0;
  wire logic [LEVEL_W-1:0] comp_level = LEVEL_W'(filt_level) + comp_add;
  wire logic gain_trip = wakeup_q && sw_en_q && !gain_low_q && (comp_level > thr_q);
  // A threshold trip in the same cycle as a high-gain command wins, as hardware sets beat clears.
  wire logic gain_low_d = ((cmd_wr && cmd_gsel == GSEL_LOW) || gain_trip) ? 1'b1 :
    (cmd_wr && cmd_gsel == GSEL_HIGH) ? 1'b0 : gain_low_q;
  wire logic [HIGH_GAIN_W-1:0] fe_gain = gain_low_q ? HIGH_GAIN_W'(low_gain_q) : high_gain_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q <= 1'b0;
      dp_addr_q <= '0;
      hrdata_q <= '0;
      hreadyout_q <= 1'b1;
    end else begin
      dp_wr_q <= wr_ok;
      dp_addr_q <= a;
      hrdata_q <= (addr_take && !hwrite) ? rd_word : '0;
      hreadyout_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      image_trim_q <= TRIM_RST;
      filt_sel_q <= FILT_SEL_RST;
      high_gain_q <= HIGH_GAIN_RST;
      low_gain_q <= LOW_GAIN_RST;
      thr_q <= THR_RST;
      step_q <= GAIN_STEP_RST;
    end else begin
      image_trim_q <= image_trim_d;
      if (wr_bw) filt_sel_q <= hwdata[FILT_SEL_W-1:0];
      if (wr_gain) begin
        high_gain_q <= hwdata[HIGH_GAIN_W-1:0];
        low_gain_q <= hwdata[GAIN_LOW_LSB +: LOW_GAIN_W];
      end
      if (wr_thr) thr_q <= hwdata[LEVEL_W-1:0];
      if (wr_step) step_q <= hwdata[GAIN_STEP_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain_low_q <= 1'b0;
      wakeup_q <= 1'b0;
      sw_en_q <= 1'b0;
      level_q <= '0;
    end else begin
      gain_low_q <= gain_low_d;
      wakeup_q <= wakeup_d;
      sw_en_q <= sw_en_d;
      level_q <= comp_level;
    end
  end

  // Low gain code carries no top bit, so the aux output drops to zero in low gain.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      iq_trim_q <= TRIM_RST;
      lna_gain_q <= HIGH_GAIN_RST[1:0];
      cf_gain_q <= HIGH_GAIN_RST[3:2];
      gain_aux_q <= HIGH_GAIN_RST[4];
      demod_q <= 1'b0;
    end else begin
      iq_trim_q <= iq_trim_d;
      lna_gain_q <= fe_gain[1:0];
      cf_gain_q <= fe_gain[3:2];
      gain_aux_q <= fe_gain[4];
      // Quadrature sign at each rising I edge tells the frequency deviation direction.
      if (lim_s_q[0] && !lim_i_d_q) demod_q <= lim_s_q[1];
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign iq_trim = iq_trim_q;
  assign lna_gain = lna_gain_q;
  assign cf_gain = cf_gain_q;
  assign gain_aux = gain_aux_q;
  assign demod_bit = demod_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_start;
    trim_start |=> trim_active ##1 trim_active;
  endproperty
  a_start: assert property (p_start) else $error("start bit did not launch search");

  property p_busy_read;
    addr_take && !hwrite && a == ADDR_TRIM |=> hrdata[TRIM_ACTIVE_BIT] == $past(trim_active);
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("active flag not visible on read");

  property p_store;
    sweep_done |=> !trim_active && image_trim_q == $past(sweep_best) && iq_trim == $past(sweep_best);
  endproperty
  a_store: assert property (p_store) else $error("best trim not stored at sweep end");

  property p_hold;
    !trim_active && !wr_trim ##1 !trim_active |-> iq_trim == $past(image_trim_q);
  endproperty
  a_hold: assert property (p_hold) else $error("trim output moved without a write");

  property p_gain_map;
    1'b1 |=> {gain_aux, cf_gain, lna_gain} == ($past(gain_low_q) ? {1'b0, $past(low_gain_q)} : $past(high_gain_q));
  endproperty
  a_gain_map: assert property (p_gain_map) else $error("front-end gain code mismatch");

  property p_trip;
    gain_trip |=> gain_low_q ##1 lna_gain == $past(low_gain_q[1:0]);
  endproperty
  a_trip: assert property (p_trip) else $error("no switch to low gain above threshold");

  property p_no_trip;
    !cmd_wr && !gain_trip |=> gain_low_q == $past(gain_low_q);
  endproperty
  a_no_trip: assert property (p_no_trip) else $error("gain changed without cause");

  property p_switch_only_wakeup;
    sw_en_q |-> wakeup_q || $past(wakeup_decision) || $past(cmd_wr);
  endproperty
  a_switch_only_wakeup: assert property (p_switch_only_wakeup) else $error("switching armed outside wakeup");

  property p_comp;
    1'b1 |=> level_q == LEVEL_W'($past(filt_level)) + ($past(gain_low_q) ? LEVEL_W'($past(step_q)) : LEVEL_W'(0));
  endproperty
  a_comp: assert property (p_comp) else $error("level compensation wrong");

  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus response not ready and okay");

  c_sweep_done: cover property (sweep_done);
  c_gain_trip: cover property (gain_trip);
  c_wakeup_cmd: cover property (cmd_wakeup && cmd_gsel == GSEL_SWITCH);
  c_level_read: cover property (addr_take && !hwrite && a == ADDR_LEVEL);

endmodule

// ### sim/front_end_model.sv
// Front-end model: analog level source and limiter pair seen by the block's pins.
// Assumes the bench chooses the level source and the limiter phase relation.
`timescale 1ns/1ps
module front_end_model
  import rssi_cal_pkg::*;
#(
  parameter logic [IQ_TRIM_W-1:0] TARGET = 7'h2B
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [IQ_TRIM_W-1:0] iq_trim,
  input wire logic image_mode,
  input wire logic [LEVEL_RAW_W-1:0] carrier,
  input wire logic q_leads,
  output logic [LEVEL_RAW_W-1:0] level_raw,
  output logic lim_i,
  output logic lim_q
);
  logic [3:0] phase_q;
  logic [3:0] ahead;
  logic [3:0] behind;
  // Only the matching trim code cancels the image; a near miss must not look almost as good.
  assign level_raw = !image_mode ? carrier : (iq_trim == TARGET) ? '0 : '1;
  assign ahead = phase_q + 4'h4;
  assign behind = phase_q - 4'h4;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= 4'h0;
      lim_i <= 1'b0;
      lim_q <= 1'b0;
    end else begin
      phase_q <= phase_q + 4'h1;
      lim_i <= phase_q[3];
      lim_q <= q_leads ? ahead[3] : behind[3];
    end
  end
endmodule

// ### sim/tb.sv
// Self-checking bench for the signal-level, gain and image-trim block.
// Assumes the front-end model on the analog pins and one AHB-Lite master.
`timescale 1ns/1ps
module tb;
  import rssi_cal_pkg::*;
  localparam int SETTLE = 200;
  localparam logic [IQ_TRIM_W-1:0] TARGET = 7'h2B;
  typedef struct {logic [31:0] exp; logic [31:0] mask; int tol;} note_t;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, lim_i, lim_q;
  logic wakeup_decision, gain_aux, demod_bit, image_mode, q_leads, rd_dp;
  logic [31:0] haddr, hwdata, hrdata, last_rd;
  logic [1:0] htrans, lna_gain, cf_gain;
  logic [2:0] hsize;
  logic [LEVEL_RAW_W-1:0] level_raw, carrier;
  logic [IQ_TRIM_W-1:0] iq_trim;
  logic [15:0] seed;
  int mismatches, comparisons, k;
  note_t notes[$];

  rssi_gain_iq_calibration #(.SETTLE_CYCLES(SETTLE)) i_rssi_gain_iq_calibration (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .level_raw(level_raw), .lim_i(lim_i), .lim_q(lim_q), .wakeup_decision(wakeup_decision),
    .iq_trim(iq_trim), .lna_gain(lna_gain), .cf_gain(cf_gain), .gain_aux(gain_aux), .demod_bit(demod_bit));
  front_end_model #(.TARGET(TARGET)) i_front_end_model (.hclk(hclk), .hresetn(hresetn), .iq_trim(iq_trim),
    .image_mode(image_mode), .carrier(carrier), .q_leads(q_leads), .level_raw(level_raw), .lim_i(lim_i),
    .lim_q(lim_q));
  assign hready = hreadyout;

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic end_of_test();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic fail(input string msg);
    mismatches++;
    $display("Error at %0t: %s", $time, msg);
  endtask

  task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) fail($sformatf("%s got %h expected %h", what, got, exp));
  endtask

  // The filtered level may rest one code off the input, so a tolerance is allowed there.
  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp, input int tol);
    comparisons++;
    if (got !== exp && !(^got !== 1'bx && (got > exp ? got - exp : exp - got) <= tol))
      fail($sformatf("read got %h expected %h", got, exp));
  endtask

  always @(posedge hclk) begin
    note_t n;
    if (rd_dp && hreadyout === 1'b1) begin
      last_rd = hrdata;
      cmp_pin({7'h0, hresp}, 8'h00, "bus response");
      if (notes.size() == 0) begin
        fail("read without a note");
      end else begin
        n = notes.pop_front();
        if (n.mask != 0) cmp_rd(hrdata & n.mask, n.exp & n.mask, n.tol);
      end
    end
  end

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 100) begin
        fail("bus timeout");
        end_of_test();
      end
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] addr, input logic [31:0] data);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, addr};
    hwrite <= w;
    hsize <= HSIZE_WORD;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= data;
    rd_dp <= !w;
    wait_ready();
    rd_dp <= 1'b0;
    @(posedge hclk);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    bus(1'b1, addr, data);
  endtask

  task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input logic [31:0] mask, input int tol);
    notes.push_back('{exp, mask, tol});
    bus(1'b0, addr, 32'h0);
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    rd_dp = 1'b0;
    wakeup_decision = 1'b0;
    image_mode = 1'b0;
    q_leads = 1'b0;
    carrier = 6'h00;
    seed = 16'h7B25;
    mismatches = 0;
    comparisons = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    cmp_pin({6'h0, lna_gain}, {6'h0, HIGH_GAIN_RST[1:0]}, "lna after reset");
    cmp_pin({6'h0, cf_gain}, {6'h0, HIGH_GAIN_RST[3:2]}, "cf after reset");
    rd(ADDR_GAIN, {20'h0, LOW_GAIN_RST, 3'h0, HIGH_GAIN_RST}, 32'h00000F1F, 0);
    rd(ADDR_THR, {24'h0, THR_RST}, 32'h000000FF, 0);
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, 32'h0, 32'hFFFFFFFF, 0);
    $display("test reset and map done");
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_GAIN, {20'h0, LOW_GAIN_RST, 3'h0, c[0], c[1:0], 2'(3 - c)});
      repeat (3) @(posedge hclk);
      cmp_pin({6'h0, lna_gain}, 8'(3 - c), "lna code");
      cmp_pin({6'h0, cf_gain}, 8'(c), "cf code");
      cmp_pin({7'h0, gain_aux}, {7'h0, c[0]}, "aux bit");
    end
    $display("test gain codes done");
    wr(ADDR_BW, 32'hFFFFFFFF);
    rd(ADDR_BW, 32'h0000000F, 32'h0000000F, 0);
    wr(ADDR_BW, 32'h0);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      carrier <= {1'b1, seed[4:0]};
      q_leads <= i[0];
      repeat (400) @(posedge hclk);
      rd(ADDR_LEVEL, {26'h0, carrier}, 32'h000001FF, 1);
      cmp_pin({7'h0, demod_bit}, {7'h0, q_leads}, "demod bit");
    end
    $display("test level path done");
    wr(ADDR_GAIN, {20'h0, 4'h9, 3'h0, 5'h1E});
    wr(ADDR_THR, 32'h00000010);
    wr(ADDR_STEP, 32'h0000000A);
    wr(ADDR_CMD, {28'h0, GSEL_SWITCH, SUB_PREAMBLE});
    repeat (50) @(posedge hclk);
    cmp_pin({6'h0, lna_gain}, 8'h02, "switch outside wakeup");
    rd(ADDR_CMD, 32'h0, 32'h00000020, 0);
    wr(ADDR_CMD, {28'h0, GSEL_SWITCH, SUB_WAKEUP});
    k = 0;
    while (lna_gain !== 2'h1 && k < 200) begin
      @(posedge hclk);
      k++;
    end
    cmp_pin({6'h0, lna_gain}, 8'h01, "lna low gain");
    cmp_pin({6'h0, cf_gain}, 8'h02, "cf low gain");
    cmp_pin({7'h0, gain_aux}, 8'h00, "aux low gain");
    rd(ADDR_LEVEL, {23'h0, 1'b1, 8'({2'h0, carrier} + 8'h0A)}, 32'h000001FF, 1);
    rd(ADDR_CMD, 32'h00000010, 32'h00000010, 0);
    wakeup_decision <= 1'b1;
    @(posedge hclk);
    wakeup_decision <= 1'b0;
    rd(ADDR_CMD, 32'h0, 32'h00000030, 0);
    wr(ADDR_CMD, {28'h0, GSEL_HIGH, SUB_CONT});
    repeat (3) @(posedge hclk);
    cmp_pin({3'h0, gain_aux, cf_gain, lna_gain}, 8'h1E, "high gain again");
    wr(ADDR_CMD, {28'h0, GSEL_LOW, SUB_DATA});
    repeat (3) @(posedge hclk);
    cmp_pin({3'h0, gain_aux, cf_gain, lna_gain}, 8'h09, "forced low gain");
    $display("test gain switching done");
    image_mode <= 1'b1;
    wr(ADDR_TRIM, 32'h00000080);
    rd(ADDR_TRIM, 32'h00000100, 32'h00000100, 0);
    // A rewrite while the search runs must be dropped.
    wr(ADDR_TRIM, 32'h00000011);
    k = 0;
    do begin
      rd(ADDR_TRIM, 32'h0, 32'h0, 0);
      k++;
    end while (last_rd[8] !== 1'b0 && k < 20000);
    if (k >= 20000) begin
      fail("trim search hang");
      end_of_test();
    end
    cmp_pin({1'b0, last_rd[6:0]}, {1'b0, TARGET}, "trim at flag fall");
    rd(ADDR_TRIM, {25'h0, TARGET}, 32'h000001FF, 0);
    cmp_pin({1'b0, iq_trim}, {1'b0, TARGET}, "applied trim");
    image_mode <= 1'b0;
    seed = lfsr(seed);
    wr(ADDR_TRIM, {25'h0, seed[6:0]});
    rd(ADDR_TRIM, {25'h0, seed[6:0]}, 32'h000001FF, 0);
    cmp_pin({1'b0, iq_trim}, {1'b0, seed[6:0]}, "restored trim");
    wr(ADDR_TRIM, 32'h0);
    cmp_pin({1'b0, iq_trim}, 8'h00, "cleared trim");
    $display("test trim search done");
    end_of_test();
  end
endmodule
